// ===== hw/irq_ctrl.sv
// Interrupt mask, factor flag and vectoring block with APB registers
// Function
// RULE1: Suspend program, then push next PC to stack
// RULE2: Load PC with page 1 vector 01H-07H
// RULE3: Save plus vector load take 12 cycles
// RULE4: Four per-pin enable bits, 1 enables
// RULE5: Timer enables 2/8/32 Hz in D2..D0
// RULE6: Converter enable in D0, others read-only
// RULE7: One shared input pin flag in D0
// RULE8: Three timer factor flags in D2..D0
// RULE9: Converter factor flag in D0
// RULE10: Reading a flag register clears it
// RULE11: Unused bits read as zero
// RULE12: Masks and flags reset to zero
// RULE13: Request only if flag, mask, global enable
// RULE14: Taking interrupt clears global enable
// RULE15: Request while halted restarts CPU clock
// RULE16: Event during clearing read keeps flag set
module irq_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [irq_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] input_port_pins,
  input wire logic [2:0] timer_ticks,
  input wire logic converter_done,
  input wire logic [irq_pkg::PC_W-1:0] cpu_pc,
  input wire logic cpu_set_ei,
  input wire logic cpu_set_di,
  input wire logic cpu_halt,
  output irq_pkg::cpu_vec_s cpu_vec,
  output logic cpu_irq_req,
  output logic cpu_clk_run,
  output logic irq
);

  function automatic logic hit(input logic [irq_pkg::ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a[irq_pkg::ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic [3:0] pin_prev_reg;
  logic [3:0] pin_en_reg;
  logic [2:0] tmr_en_reg;
  logic conv_en_reg;
  irq_pkg::flags_s flag_reg;
  logic gie_reg;
  logic [1:0] ev_stat_reg;
  logic [1:0] ev_mask_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  irq_pkg::seq_e state_reg;
  logic [3:0] cnt_reg;
  irq_pkg::cpu_vec_s vec_reg;
  logic irq_req_reg;
  logic clk_run_reg;
  logic irq_reg;

  logic [3:0] rd_data;
  logic map_hit;
  logic done;
  logic wr_done;
  logic rd_done;
  logic [4:0] pending;
  logic any_pending;
  logic accept;
  logic [3:0] pin_rise;
  logic [2:0] vec_code;

  assign done = psel && penable && pready_reg;
  assign wr_done = done && pwrite;
  assign rd_done = done && !pwrite;
  assign pin_rise = pin_sync_reg & ~pin_prev_reg;

  // Pins are asynchronous; the edge detector reads only the second and third stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= irq_pkg::RST_NIBBLE;
      pin_sync_reg <= irq_pkg::RST_NIBBLE;
      pin_prev_reg <= irq_pkg::RST_NIBBLE;
    end else begin
      pin_meta_reg <= input_port_pins;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // Unmasked requests per source
  assign pending = {flag_reg.conv & conv_en_reg,
                    flag_reg.timer & tmr_en_reg,
                    flag_reg.pin & (|pin_en_reg)};
  assign any_pending = |pending;
  assign accept = irq_req_reg && gie_reg && (state_reg == irq_pkg::ST_IDLE);
  assign vec_code = {|pending[3:1], pending[4], pending[0]};

  // Read mux; only defined bits are driven, the rest stay zero
  always_comb begin
    rd_data = 4'h0;
    map_hit = 1'b1;
    if (hit(paddr, irq_pkg::IDX_PIN_EN)) begin
      rd_data = pin_en_reg; // [RULE4]
    end else if (hit(paddr, irq_pkg::IDX_TMR_EN)) begin
      rd_data = {1'b0, tmr_en_reg}; // [RULE5] [RULE11]
    end else if (hit(paddr, irq_pkg::IDX_CONV_EN)) begin
      rd_data = {3'h0, conv_en_reg}; // [RULE6] [RULE11]
    end else if (hit(paddr, irq_pkg::IDX_PIN_FLAG)) begin
      rd_data = {3'h0, flag_reg.pin}; // [RULE7] [RULE11]
    end else if (hit(paddr, irq_pkg::IDX_TMR_FLAG)) begin
      rd_data = {1'b0, flag_reg.timer}; // [RULE8] [RULE11]
    end else if (hit(paddr, irq_pkg::IDX_CONV_FLAG)) begin
      rd_data = {3'h0, flag_reg.conv}; // [RULE9] [RULE11]
    end else if (hit(paddr, irq_pkg::IDX_CTRL)) begin
      rd_data = {3'h0, gie_reg};
    end else if (hit(paddr, irq_pkg::IDX_EV_STAT)) begin
      rd_data = {2'h0, ev_stat_reg};
    end else if (hit(paddr, irq_pkg::IDX_EV_MASK)) begin
      rd_data = {2'h0, ev_mask_reg};
    end else begin
      map_hit = 1'b0;
    end
  end

  // APB slave with one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (done) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (psel && penable) begin
      pready_reg <= 1'b1;
      pslverr_reg <= !map_hit;
      prdata_reg <= pwrite ? 32'h0000_0000 : {28'h0000000, rd_data};
    end
  end

  // Mask registers; writes to read-only positions are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_en_reg <= irq_pkg::RST_NIBBLE; // [RULE12]
      tmr_en_reg <= irq_pkg::RST_NIBBLE[2:0]; // [RULE12]
      conv_en_reg <= 1'b0; // [RULE12]
      ev_mask_reg <= irq_pkg::RST_EV;
    end else if (wr_done) begin
      if (hit(paddr, irq_pkg::IDX_PIN_EN)) begin
        pin_en_reg <= pwdata[3:0]; // [RULE4]
      end
      if (hit(paddr, irq_pkg::IDX_TMR_EN)) begin
        tmr_en_reg <= pwdata[2:0]; // [RULE5]
      end
      if (hit(paddr, irq_pkg::IDX_CONV_EN)) begin
        conv_en_reg <= pwdata[0]; // [RULE6]
      end
      if (hit(paddr, irq_pkg::IDX_EV_MASK)) begin
        ev_mask_reg <= pwdata[1:0];
      end
    end
  end

  // Factor flags. Only the bits returned by the read are cleared, so an
  // event landing between data capture and the clearing edge survives.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= '0; // [RULE12]
    end else begin
      if (rd_done && hit(paddr, irq_pkg::IDX_PIN_FLAG) && prdata_reg[0]) begin
        flag_reg.pin <= |(pin_rise & pin_en_reg); // [RULE10] [RULE16]
      end else if (|(pin_rise & pin_en_reg)) begin
        flag_reg.pin <= 1'b1;
      end
      if (rd_done && hit(paddr, irq_pkg::IDX_TMR_FLAG)) begin
        flag_reg.timer <= (flag_reg.timer & ~prdata_reg[2:0])
                          | timer_ticks; // [RULE10] [RULE16]
      end else begin
        flag_reg.timer <= flag_reg.timer | timer_ticks;
      end
      if (rd_done && hit(paddr, irq_pkg::IDX_CONV_FLAG) && prdata_reg[0]) begin
        flag_reg.conv <= converter_done; // [RULE10] [RULE16]
      end else if (converter_done) begin
        flag_reg.conv <= 1'b1;
      end
    end
  end

  // Global enable; the dispatch clear beats a same-cycle enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_reg <= 1'b0;
    end else if (accept) begin
      gie_reg <= 1'b0; // [RULE14]
    end else if (cpu_set_di) begin
      gie_reg <= 1'b0;
    end else if (cpu_set_ei) begin
      gie_reg <= 1'b1;
    end else if (wr_done && hit(paddr, irq_pkg::IDX_CTRL)) begin
      gie_reg <= pwdata[irq_pkg::CTRL_GIE];
    end
  end

  // Request to the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_reg <= 1'b0;
    end else begin
      irq_req_reg <= any_pending && gie_reg && !accept
                     && (state_reg == irq_pkg::ST_IDLE); // [RULE13]
    end
  end

  // Vectoring sequence: hold the core, push return PC, load vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= irq_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      vec_reg <= '0;
    end else begin
      vec_reg.push <= 1'b0;
      vec_reg.load <= 1'b0;
      unique case (state_reg)
        irq_pkg::ST_IDLE: begin
          if (accept) begin
            state_reg <= irq_pkg::ST_SEQ;
            cnt_reg <= 4'h0;
            vec_reg.hold <= 1'b1; // [RULE1]
            vec_reg.push_pc <= cpu_pc;
            vec_reg.load_pc <= {irq_pkg::VEC_PAGE, 5'h00, vec_code}; // [RULE2]
          end
        end
        irq_pkg::ST_SEQ: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == irq_pkg::VEC_CNT_PUSH) begin
            vec_reg.push <= 1'b1; // [RULE1]
          end
          if (cnt_reg == irq_pkg::VEC_CNT_LOAD) begin
            vec_reg.load <= 1'b1; // [RULE2]
          end
          if (cnt_reg == irq_pkg::VEC_CNT_LAST) begin
            state_reg <= irq_pkg::ST_IDLE; // [RULE3]
            vec_reg.hold <= 1'b0;
          end
        end
      endcase
    end
  end

  // Halt: clock stops on the halt command, any unmasked request wakes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_run_reg <= 1'b1;
    end else if (any_pending) begin
      clk_run_reg <= 1'b1; // [RULE15]
    end else if (cpu_halt) begin
      clk_run_reg <= 1'b0;
    end
  end

  // Block event status, read to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_stat_reg <= irq_pkg::RST_EV;
      irq_reg <= 1'b0;
    end else begin
      if (rd_done && hit(paddr, irq_pkg::IDX_EV_STAT)) begin
        ev_stat_reg <= (ev_stat_reg & ~prdata_reg[1:0])
                       | {!clk_run_reg && any_pending, accept};
      end else begin
        ev_stat_reg <= ev_stat_reg | {!clk_run_reg && any_pending, accept};
      end
      irq_reg <= |(ev_stat_reg & ev_mask_reg);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign cpu_vec = vec_reg;
  assign cpu_irq_req = irq_req_reg;
  assign cpu_clk_run = clk_run_reg;
  assign irq = irq_reg;

  AST_SEQ_LEN: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
    $rose(vec_reg.hold) |-> ##10 vec_reg.hold ##1 (vec_reg.load && vec_reg.hold)
      ##1 !vec_reg.hold)
    else $error("vector sequence not 12 cycles");

  AST_PUSH_FIRST: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    $rose(vec_reg.hold) |-> !vec_reg.push ##1
      (vec_reg.push && vec_reg.push_pc == $past(cpu_pc, 2)))
    else $error("return address not pushed after suspend");

  AST_VEC_RANGE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    vec_reg.load |-> (vec_reg.load_pc[11:8] == irq_pkg::VEC_PAGE)
      && (vec_reg.load_pc[7:0] >= irq_pkg::VEC_MIN)
      && (vec_reg.load_pc[7:0] <= irq_pkg::VEC_MAX))
    else $error("vector outside page 1 range");

  AST_GIE_CLR: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
    $rose(vec_reg.hold) |-> !gie_reg)
    else $error("global enable not cleared on dispatch");

  AST_REQ_COND: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
    irq_req_reg |-> $past(gie_reg) && $past(any_pending))
    else $error("request without flag, mask and enable");

  AST_READ_CLR: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
    rd_done && hit(paddr, irq_pkg::IDX_CONV_FLAG) && prdata_reg[0]
      && !converter_done |=> !flag_reg.conv)
    else $error("flag not cleared by read");

  AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
    timer_ticks[irq_pkg::TMR_FAST] |=> flag_reg.timer[irq_pkg::TMR_FAST])
    else $error("timer event lost");

  AST_RSV_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
    pready_reg |-> (prdata_reg[31:4] == 28'h0000000)
      && (!hit(paddr, irq_pkg::IDX_TMR_FLAG) || !prdata_reg[3]))
    else $error("unused bits not zero");

  AST_PIN_EN_WR: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
    wr_done && hit(paddr, irq_pkg::IDX_PIN_EN) |=> pin_en_reg == $past(pwdata[3:0]))
    else $error("pin enable write lost");

  AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
    !clk_run_reg && any_pending |=> clk_run_reg)
    else $error("halt not released by request");

  AST_TMR_EN_WR: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    wr_done && hit(paddr, irq_pkg::IDX_TMR_EN) |=> tmr_en_reg == $past(pwdata[2:0]))
    else $error("timer enable write lost");

  AST_CONV_EN_WR: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    wr_done && hit(paddr, irq_pkg::IDX_CONV_EN) |=> conv_en_reg == $past(pwdata[0]))
    else $error("converter enable write lost");

  AST_PIN_CLR: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
    rd_done && hit(paddr, irq_pkg::IDX_PIN_FLAG) && prdata_reg[0]
      && !(|(pin_rise & pin_en_reg)) |=> !flag_reg.pin)
    else $error("pin flag not cleared by read");

  // Flags ignore bus writes; only events and clearing reads change them
  AST_FLAG_RO: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
    wr_done && hit(paddr, irq_pkg::IDX_TMR_FLAG) && (timer_ticks == 3'h0)
      |=> $stable(flag_reg.timer))
    else $error("timer flags changed by write");

  AST_NO_REQ_IN_SEQ: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
    vec_reg.hold |-> !irq_req_reg)
    else $error("request raised during vectoring");

  AST_VEC_STABLE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    !accept |=> $stable(vec_reg.load_pc) && $stable(vec_reg.push_pc))
    else $error("vector addresses changed without dispatch");

  COV_DISPATCH: cover property (@(posedge pclk) disable iff (!presetn)
    accept ##12 vec_reg.load);
  COV_CLEAR_RACE: cover property (@(posedge pclk) disable iff (!presetn)
    rd_done && hit(paddr, irq_pkg::IDX_TMR_FLAG) && ((prdata_reg[2:0] & timer_ticks) != 3'h0));
  COV_WAKE: cover property (@(posedge pclk) disable iff (!presetn)
    !clk_run_reg ##1 clk_run_reg);
  COV_READ_CLR: cover property (@(posedge pclk) disable iff (!presetn)
    rd_done && hit(paddr, irq_pkg::IDX_TMR_FLAG) && (prdata_reg[2:0] != 3'h0));
  COV_SLVERR: cover property (@(posedge pclk) disable iff (!presetn)
    pready_reg && pslverr_reg);

endmodule

// ===== hw/irq_pkg.sv
// Constants and types for the interrupt mask, flag and vectoring block
package irq_pkg;
  localparam int ADDR_W = 10;
  localparam int PC_W = 12;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PIN_EN = 8'hE8;
  localparam logic [7:0] IDX_TMR_EN = 8'hEB;
  localparam logic [7:0] IDX_CONV_EN = 8'hEC;
  localparam logic [7:0] IDX_PIN_FLAG = 8'hED;
  localparam logic [7:0] IDX_TMR_FLAG = 8'hEF;
  localparam logic [7:0] IDX_CONV_FLAG = 8'hF0;
  localparam logic [7:0] IDX_CTRL = 8'hF4;
  localparam logic [7:0] IDX_EV_STAT = 8'hF5;
  localparam logic [7:0] IDX_EV_MASK = 8'hF6;
  // Field positions
  localparam int TMR_SLOW = 2;
  localparam int TMR_MID = 1;
  localparam int TMR_FAST = 0;
  localparam int CTRL_GIE = 0;
  localparam int EV_DISPATCH = 0;
  localparam int EV_WAKE = 1;
  // Reset values
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [1:0] RST_EV = 2'h0;
  // Vectoring sequence
  localparam int VEC_CYCLES = 12;
  localparam logic [3:0] VEC_CNT_LAST = 4'(VEC_CYCLES - 1);
  localparam logic [3:0] VEC_CNT_LOAD = 4'(VEC_CYCLES - 2);
  localparam logic [3:0] VEC_CNT_PUSH = 4'h0;
  localparam logic [3:0] VEC_PAGE = 4'h1;
  localparam logic [7:0] VEC_MIN = 8'h01;
  localparam logic [7:0] VEC_MAX = 8'h07;

  typedef struct packed {
    logic conv;
    logic [2:0] timer;
    logic pin;
  } flags_s;

  typedef struct packed {
    logic hold;
    logic push;
    logic [PC_W-1:0] push_pc;
    logic load;
    logic [PC_W-1:0] load_pc;
  } cpu_vec_s;

  typedef enum logic [0:0] {ST_IDLE, ST_SEQ} seq_e;
endpackage

// ===== verification/cpu_model.sv
// Behavioural CPU core that runs a program counter and times vectoring
module cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire irq_pkg::cpu_vec_s cpu_vec,
  input wire logic cpu_clk_run,
  output logic [11:0] cpu_pc,
  output logic [11:0] acc_pc,
  output int hold_len,
  output int push_at,
  output int load_at
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] last_pc;
  logic hold_q;
  int hc;
  // Counter stalls while halted or suspended, as a real core would
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_pc <= 12'h200;
      last_pc <= 12'h000;
      acc_pc <= 12'h000;
      hold_q <= 1'b0;
      hc <= 0;
      hold_len <= 0;
      push_at <= 0;
      load_at <= 0;
    end else begin
      if (cpu_clk_run && !cpu_vec.hold) cpu_pc <= cpu_pc + 12'h001;
      last_pc <= cpu_pc;
      hold_q <= cpu_vec.hold;
      hc <= cpu_vec.hold ? hc + 1 : 0;
      if (cpu_vec.hold && !hold_q) acc_pc <= last_pc;
      if (cpu_vec.push) push_at <= hc + 1;
      if (cpu_vec.load) load_at <= hc + 1;
      if (!cpu_vec.hold && hold_q) hold_len <= hc;
    end
  end
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the interrupt block against a register model
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, cpu_irq_req, cpu_clk_run, irq;
  logic cpu_set_ei = 0, cpu_set_di = 0, cpu_halt = 0, converter_done = 0;
  logic [3:0] input_port_pins = 4'h0;
  logic [2:0] timer_ticks = 3'h0;
  logic [11:0] cpu_pc, acc_pc;
  irq_pkg::cpu_vec_s cpu_vec;
  int hold_len, push_at, load_at, err_count = 0, tests_run = 0, cyc = 0;
  int mdl [9];
  int wmv [9] = '{15, 7, 1, 0, 0, 0, 1, 0, 3};
  logic [7:0] idx [9] = '{8'hE8, 8'hEB, 8'hEC, 8'hED, 8'hEF, 8'hF0,
    irq_pkg::IDX_CTRL, irq_pkg::IDX_EV_STAT, irq_pkg::IDX_EV_MASK};

  irq_ctrl uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .input_port_pins, .timer_ticks, .converter_done,
    .cpu_pc, .cpu_set_ei, .cpu_set_di, .cpu_halt, .cpu_vec, .cpu_irq_req,
    .cpu_clk_run, .irq);
  cpu_model cpu (.pclk, .presetn, .cpu_vec, .cpu_clk_run, .cpu_pc, .acc_pc,
    .hold_len, .push_at, .load_at);

  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic [7:0] i, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // No local limit: only the bench timeout ends a stuck transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wr(input int k, input int d);
    apb(idx[k], 1, d);
    if (wmv[k] != 0) mdl[k] = d & wmv[k];
  endtask

  task automatic chk(input int k);
    apb(idx[k], 0, 0);
    cmp(rd, mdl[k]);
    cmp(err, 0);
    if (k inside {3, 4, 5, 7}) mdl[k] = 0;
  endtask

  task automatic do_reset();
    presetn <= 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    foreach (mdl[k]) mdl[k] = 0;
  endtask

  task automatic tick(input logic [2:0] t, input logic c);
    @(posedge pclk);
    timer_ticks <= t;
    converter_done <= c;
    @(posedge pclk);
    timer_ticks <= 0;
    converter_done <= 0;
    mdl[4] |= t;
    mdl[5] |= c;
  endtask

  // Pins pass a synchroniser, so hold them long enough to be seen
  task automatic pin(input logic [3:0] p);
    @(posedge pclk);
    input_port_pins <= p;
    repeat (6) @(posedge pclk);
    input_port_pins <= 0;
    if ((p & mdl[0]) != 0) mdl[3] = 1;
    repeat (4) @(posedge pclk);
  endtask

  task automatic cpu_pulse(input int k);
    @(posedge pclk);
    {cpu_halt, cpu_set_di, cpu_set_ei} <= 3'(1 << k);
    @(posedge pclk);
    {cpu_halt, cpu_set_di, cpu_set_ei} <= 3'b000;
    if (k == 0) mdl[6] = 1;
    if (k == 1) mdl[6] = 0;
  endtask

  // Source 0 pin, 1 converter, 2 timer
  task automatic vec(input int s);
    case (s)
      0: begin
        wr(0, $urandom_range(15, 1));
        pin(4'(mdl[0]));
      end
      1: begin
        wr(2, 1);
        tick(0, 1);
      end
      default: begin
        wr(1, 7);
        tick(3'($urandom_range(7, 1)), 0);
      end
    endcase
    cmp(cpu_irq_req, 0);
    if (s == 0) cpu_pulse(0);
    else wr(6, 1);
    repeat (2) @(posedge pclk);
    cmp(cpu_irq_req, 1);
    while (cpu_vec.hold !== 1'b1) begin
      @(posedge pclk);
    end
    repeat (16) @(posedge pclk);
    cmp(hold_len, 12);
    cmp(push_at, 2);
    cmp(cpu_vec.push_pc, acc_pc);
    cmp(load_at, 12);
    cmp(cpu_vec.load_pc, {4'h1, 5'h00, 3'(1 << s)});
    cmp(cpu_irq_req, 0);
    mdl[6] = 0;
    mdl[7] |= 1;
    chk(6);
    chk(s == 0 ? 3 : 6 - s);
    wr(s == 0 ? 0 : 3 - s, 0);
  endtask

  initial begin
    void'($urandom(32'h8DC9C6CF));
    do_reset();
    foreach (idx[k]) chk(k);
    for (int k = 0; k < 3; k++) begin
      wr(k, $urandom);
      chk(k);
      wr(k, 0);
    end
    wr(0, 15);
    tick(3'($urandom_range(7, 1)), 1);
    pin(4'($urandom_range(15, 1)));
    for (int k = 3; k < 6; k++) begin
      wr(k, 32'hF);
      chk(k);
      chk(k);
    end
    wr(0, 0);
    apb(8'h10, 0, 0);
    cmp(rd, 0);
    cmp(err, 1);
    wr(6, 1);
    tick(7, 1);
    pin(4'hF);
    repeat (3) @(posedge pclk);
    cmp(cpu_irq_req, 0);
    chk(3);
    chk(4);
    chk(5);
    cpu_pulse(1);
    chk(6);
    for (int s = 0; s < 3; s++) vec(s);
    wr(1, 1);
    cpu_pulse(2);
    repeat (2) @(posedge pclk);
    cmp(cpu_clk_run, 0);
    tick(1, 0);
    repeat (3) @(posedge pclk);
    cmp(cpu_clk_run, 1);
    mdl[7] |= 2;
    wr(8, 3);
    repeat (2) @(posedge pclk);
    cmp(irq, (mdl[7] & mdl[8]) != 0);
    chk(7);
    repeat (2) @(posedge pclk);
    cmp(irq, 0);
    chk(4);
    // Flag set, then a new event lands on the clearing edge
    tick(1, 0);
    fork
      chk(4);
      begin
        repeat (3) @(posedge pclk);
        timer_ticks <= 3'b001;
        @(posedge pclk);
        timer_ticks <= 3'b000;
      end
    join
    mdl[4] = 1;
    chk(4);
    wr(0, 15);
    do_reset();
    foreach (idx[k]) chk(k);
    stop_test();
  end
endmodule
